/* verilog/msfd_consts.vh */
// Constants for the serial-line slave function dispatcher
`ifndef MSFD_CONSTS_VH
`define MSFD_CONSTS_VH

// Function codes
`define MSFD_FC_RD_HOLD   8'h03
`define MSFD_FC_RD_IN     8'h04
`define MSFD_FC_WR_ONE    8'h06
`define MSFD_FC_DIAG      8'h08
`define MSFD_FC_EVT_CNT   8'h0b
`define MSFD_FC_WR_MANY   8'h10
`define MSFD_FC_DEV_INFO  8'h2b
`define MSFD_FC_SCATTER   8'h64
`define MSFD_FC_EXC_BIT   8'h80

// Subfunction codes
`define MSFD_SUB_SCATTER  8'h04
`define MSFD_SUB_SET_DT   8'h10
`define MSFD_SUB_CLR_CNT  8'h0a
`define MSFD_SUB_CNT_LO   8'h0b
`define MSFD_SUB_CNT_HI   8'h12

// Exception codes
`define MSFD_EXC_NONE     8'h00
`define MSFD_EXC_FUNC     8'h01
`define MSFD_EXC_VALUE    8'h03
`define MSFD_EXC_BUSY     8'h06
`define MSFD_EXC_NAK      8'h07

// Limits
`define MSFD_SCAT_MAX     8'h64
`define MSFD_RD_MAX       16'h007d
`define MSFD_WR_MAX       16'h007b
`define MSFD_MIN_FRAME    9'h004
`define MSFD_BCAST_ADDR   8'h00

// Check value generator
`define MSFD_CRC_INIT     16'hffff
`define MSFD_CRC_POLY     16'ha001

// Diagnostic counter slots (counter number minus one)
`define MSFD_CNT_BUS      0
`define MSFD_CNT_COMERR   1
`define MSFD_CNT_EXC      2
`define MSFD_CNT_SLAVE    3
`define MSFD_CNT_NORESP   4
`define MSFD_CNT_NAK      5
`define MSFD_CNT_BUSY     6
`define MSFD_CNT_OVERRUN  7
`define MSFD_CNT_EVENT    8
`define MSFD_CNT_NUM      9

`endif

/* verilog/msfd_dispatch.v */
// Serial-line slave request dispatcher with diagnostic counters and exception replies
// Functional notes
// - Scattered read request: address, 0x64, count, sub 0x04, number, addresses high first.
// - Scattered reply echoes header then register values high byte first, request order.
// - Function 6 writes one register, function 16 writes a block.
// - Function 43 subfunction 16 writes date and time.
// - Function 8 subfunction 10 clears every diagnostic counter.
// - Subfunctions 11 to 14 return message, error, exception and slave counts.
// - Subfunction 15 returns the broadcast message count.
// - Subfunctions 16 and 17 return exception 07 and 06 counts.
// - Subfunction 18 returns the character overrun error count.
// - Function 11 returns the communication event counter, the ninth.
// - Exception counter counts exception replies and incorrect broadcast requests.
// - Counters wrap to zero past 65535, never saturate.
// - Counters clear at power loss and at communication parameter change.
// - No reply to a request with a communication error or not received.
// - Error-free request that cannot be serviced gets an exception reply.
// - Exception frame: address, exception function, exception code, two check bytes.
// - Exception function code is request function plus 0x80.
// - Frame ends with a 16-bit check value over the whole message.
// - A scattered read names at most 100 addresses.
// - Exception 06 tells the master the slave is busy; retry later.
`timescale 1ns/10ps
`include "msfd_consts.vh"

module msfd_dispatch #(
  parameter BUF_DEPTH = 256
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [7:0]  slave_addr,
  input  wire        comm_param_chg,
  input  wire        dev_busy,
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  input  wire        rx_end,
  input  wire        rx_err,
  input  wire        rx_overrun,
  input  wire        tx_ready,
  input  wire        reg_ack,
  input  wire [15:0] reg_rdata,
  input  wire [7:0]  reg_exc,
  output reg  [7:0]  tx_byte,
  output reg         tx_valid,
  output reg         reg_req,
  output reg         reg_we,
  output reg  [15:0] reg_addr,
  output reg  [15:0] reg_wdata,
  output reg         dt_wr,
  output reg  [55:0] dt_data
);

  localparam S_RX   = 3'd0;
  localparam S_DEC  = 3'd1;
  localparam S_REQ  = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_DONE = 3'd4;
  localparam S_TX   = 3'd5;

  localparam OP_EXC  = 3'd0;
  localparam OP_RD   = 3'd1;
  localparam OP_WR   = 3'd2;
  localparam OP_DT   = 3'd3;
  localparam OP_CLR  = 3'd4;
  localparam OP_DIAG = 3'd5;
  localparam OP_EVT  = 3'd6;

  reg  [7:0]   rbuf [0:BUF_DEPTH-1];
  reg  [7:0]   obuf [0:BUF_DEPTH-1];
  reg  [2:0]   state;
  reg  [8:0]   rx_len;
  reg          rx_long;
  reg          bcast;
  reg          ev_ok;
  reg          scat;
  reg  [15:0]  base;
  reg  [6:0]   item;
  reg  [6:0]   n_items;
  reg  [8:0]   olen;
  reg  [8:0]   optr;
  reg  [15:0]  crc;
  reg  [8:0]   inc;
  reg          clr_all;
  wire [143:0] cnt_flat;

  // Decode results
  reg  [2:0]   d_op;
  reg  [7:0]   d_exc;
  reg  [6:0]   d_n;
  reg  [15:0]  d_qty;
  reg  [7:0]   d_scn;
  reg  [7:0]   d_sel;

  // Item address and write data for the register loop
  wire [7:0]   sidx      = 8'd5 + {item, 1'b0};
  wire [15:0]  item_addr = scat ? {rbuf[sidx], rbuf[sidx + 8'd1]} : base + {9'h000, item};
  wire [15:0]  item_wdat = (rbuf[1] == `MSFD_FC_WR_ONE) ? {rbuf[4], rbuf[5]} :
                           {rbuf[sidx + 8'd2], rbuf[sidx + 8'd3]};
  wire [15:0]  diag_cnt  = cnt_flat[{d_sel[3:0], 4'h0} +: 16];
  wire [15:0]  evt_cnt   = cnt_flat[`MSFD_CNT_EVENT*16 +: 16];
  wire [7:0]   tx_next   = (optr < olen) ? obuf[optr[7:0]] : ((optr == olen) ? crc[7:0] : crc[15:8]);

  // Reflected check value step, one byte, low bit first
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        x = x[0] ? ((x >> 1) ^ `MSFD_CRC_POLY) : (x >> 1);
      end
      crc_byte = x;
    end
  endfunction

  // Diagnostic counters; natural 16-bit wrap, clear beats increment
  genvar g;
  generate
    for (g = 0; g < `MSFD_CNT_NUM; g = g + 1) begin : g_cnt
      reg [15:0] cnt;
      always @(posedge core_clk) begin
        if (sys_rst || comm_param_chg || clr_all) begin
          cnt <= 16'h0000;
        end else if (inc[g]) begin
          cnt <= cnt + 16'h0001;
        end
      end
      assign cnt_flat[g*16 +: 16] = cnt;
    end
  endgenerate

  // Request decode; a busy device refuses register and clock work only
  always @* begin
    d_op  = OP_EXC;
    d_exc = `MSFD_EXC_NONE;
    d_qty = {rbuf[4], rbuf[5]};
    d_n   = d_qty[6:0];
    d_scn = (rbuf[2] - 8'd2) >> 1;
    d_sel = rbuf[3] - `MSFD_SUB_CNT_LO;
    case (rbuf[1])
      `MSFD_FC_RD_HOLD, `MSFD_FC_RD_IN: begin
        if (d_qty == 16'h0000 || d_qty > `MSFD_RD_MAX) d_exc = `MSFD_EXC_VALUE;
        else d_op = OP_RD;
      end
      `MSFD_FC_SCATTER: begin
        d_n = d_scn[6:0];
        if (rbuf[3] != `MSFD_SUB_SCATTER || rbuf[2] < 8'd4 || rbuf[2][0] ||
            d_scn > `MSFD_SCAT_MAX) d_exc = `MSFD_EXC_VALUE;
        else d_op = OP_RD;
      end
      `MSFD_FC_WR_ONE: begin
        d_n  = 7'd1;
        d_op = OP_WR;
      end
      `MSFD_FC_WR_MANY: begin
        if (d_qty == 16'h0000 || d_qty > `MSFD_WR_MAX || rbuf[6] != {d_qty[6:0], 1'b0})
          d_exc = `MSFD_EXC_VALUE;
        else d_op = OP_WR;
      end
      `MSFD_FC_DEV_INFO: begin
        if (rbuf[2] == `MSFD_SUB_SET_DT) d_op = OP_DT;
        else d_exc = `MSFD_EXC_FUNC;
      end
      `MSFD_FC_DIAG: begin
        if (rbuf[2] != 8'h00) d_exc = `MSFD_EXC_FUNC;
        else if (rbuf[3] == `MSFD_SUB_CLR_CNT) d_op = OP_CLR;
        else if (rbuf[3] >= `MSFD_SUB_CNT_LO && rbuf[3] <= `MSFD_SUB_CNT_HI) d_op = OP_DIAG;
        else d_exc = `MSFD_EXC_FUNC;
      end
      `MSFD_FC_EVT_CNT: d_op = OP_EVT;
      default: d_exc = `MSFD_EXC_FUNC;
    endcase
    if (dev_busy && (d_op == OP_RD || d_op == OP_WR || d_op == OP_DT)) begin
      d_exc = `MSFD_EXC_BUSY;
    end
    if (d_exc != `MSFD_EXC_NONE) begin
      d_op = OP_EXC;
    end
  end

  // Main sequencer: receive, decode, register loop, transmit
  always @(posedge core_clk) begin : p_seq
    integer k;
    inc     <= 9'h000;
    clr_all <= 1'b0;
    dt_wr   <= 1'b0;
    reg_req <= 1'b0;
    if (sys_rst) begin
      state     <= S_RX;
      rx_len    <= 9'h000;
      rx_long   <= 1'b0;
      bcast     <= 1'b0;
      ev_ok     <= 1'b0;
      scat      <= 1'b0;
      base      <= 16'h0000;
      item      <= 7'h00;
      n_items   <= 7'h00;
      olen      <= 9'h000;
      optr      <= 9'h000;
      crc       <= `MSFD_CRC_INIT;
      tx_byte   <= 8'h00;
      tx_valid  <= 1'b0;
      reg_we    <= 1'b0;
      reg_addr  <= 16'h0000;
      reg_wdata <= 16'h0000;
      dt_data   <= 56'h0;
    end else begin
      case (state)
        S_RX: begin
          if (rx_valid) begin
            if (rx_len < BUF_DEPTH) begin
              rbuf[rx_len[7:0]] <= rx_byte;
              rx_len <= rx_len + 9'h001;
            end else begin
              rx_long <= 1'b1;
            end
          end
          if (rx_end) begin
            rx_len  <= 9'h000;
            rx_long <= 1'b0;
            if (rx_err || rx_overrun || rx_long || rx_len < `MSFD_MIN_FRAME) begin
              inc[`MSFD_CNT_COMERR]  <= 1'b1;
              inc[`MSFD_CNT_OVERRUN] <= rx_overrun;
            end else begin
              inc[`MSFD_CNT_BUS] <= 1'b1;
              if (rbuf[0] == slave_addr || rbuf[0] == `MSFD_BCAST_ADDR) begin
                inc[`MSFD_CNT_SLAVE]  <= 1'b1;
                inc[`MSFD_CNT_NORESP] <= (rbuf[0] == `MSFD_BCAST_ADDR);
                bcast <= (rbuf[0] == `MSFD_BCAST_ADDR);
                state <= S_DEC;
              end
            end
          end
        end
        S_DEC: begin
          // Echo the request head by default; each op overwrites what differs
          for (k = 0; k < 12; k = k + 1) begin
            obuf[k] <= rbuf[k];
          end
          ev_ok   <= 1'b1;
          item    <= 7'h00;
          n_items <= d_n;
          base    <= {rbuf[2], rbuf[3]};
          scat    <= (rbuf[1] == `MSFD_FC_SCATTER);
          olen    <= 9'd6;
          state   <= S_DONE;
          case (d_op)
            OP_RD: begin
              if (rbuf[1] == `MSFD_FC_SCATTER) begin
                olen <= 9'd5;
              end else begin
                obuf[2] <= {d_n, 1'b0};
                olen    <= 9'd3;
              end
              state <= S_REQ;
            end
            OP_WR: state <= S_REQ;
            OP_DT: begin
              dt_wr   <= 1'b1;
              dt_data <= {rbuf[5], rbuf[6], rbuf[7], rbuf[8], rbuf[9], rbuf[10], rbuf[11]};
              olen    <= 9'd12;
            end
            OP_CLR: clr_all <= 1'b1;
            OP_DIAG: begin
              obuf[4] <= diag_cnt[15:8];
              obuf[5] <= diag_cnt[7:0];
            end
            OP_EVT: begin
              ev_ok   <= 1'b0;
              obuf[2] <= 8'h00;
              obuf[3] <= 8'h00;
              obuf[4] <= evt_cnt[15:8];
              obuf[5] <= evt_cnt[7:0];
            end
            default: begin
              ev_ok   <= 1'b0;
              obuf[1] <= rbuf[1] | `MSFD_FC_EXC_BIT;
              obuf[2] <= d_exc;
              olen    <= 9'd3;
              inc[`MSFD_CNT_EXC]  <= 1'b1;
              inc[`MSFD_CNT_BUSY] <= (d_exc == `MSFD_EXC_BUSY);
            end
          endcase
        end
        S_REQ: begin
          reg_req   <= 1'b1;
          reg_we    <= (rbuf[1] == `MSFD_FC_WR_ONE) || (rbuf[1] == `MSFD_FC_WR_MANY);
          reg_addr  <= item_addr;
          reg_wdata <= item_wdat;
          state     <= S_WAIT;
        end
        S_WAIT: begin
          if (reg_ack) begin
            if (reg_exc != `MSFD_EXC_NONE) begin
              // A refused access aborts the loop; writes already done stay done
              ev_ok   <= 1'b0;
              obuf[1] <= rbuf[1] | `MSFD_FC_EXC_BIT;
              obuf[2] <= reg_exc;
              olen    <= 9'd3;
              inc[`MSFD_CNT_EXC]  <= 1'b1;
              inc[`MSFD_CNT_NAK]  <= (reg_exc == `MSFD_EXC_NAK);
              inc[`MSFD_CNT_BUSY] <= (reg_exc == `MSFD_EXC_BUSY);
              state   <= S_DONE;
            end else begin
              if (!reg_we) begin
                obuf[olen[7:0]]           <= reg_rdata[15:8];
                obuf[olen[7:0] + 8'd1]    <= reg_rdata[7:0];
                olen                      <= olen + 9'd2;
              end
              item  <= item + 7'd1;
              state <= (item + 7'd1 == n_items) ? S_DONE : S_REQ;
            end
          end
        end
        S_DONE: begin
          inc[`MSFD_CNT_EVENT] <= ev_ok;
          optr <= 9'h000;
          crc  <= `MSFD_CRC_INIT;
          // Broadcasts are carried out but never answered
          state <= bcast ? S_RX : S_TX;
        end
        S_TX: begin
          // One idle cycle per byte keeps the byte register simple
          if (!tx_valid) begin
            tx_byte  <= tx_next;
            tx_valid <= 1'b1;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            if (optr < olen) begin
              crc <= crc_byte(crc, tx_byte);
            end
            optr <= optr + 9'h001;
            if (optr == olen + 9'h001) begin
              state <= S_RX;
            end
          end
        end
        default: state <= S_RX;
      endcase
    end
  end

endmodule // msfd_dispatch

/* dv/msfd_monitor.sv */
// Port checker for the slave request dispatcher
`timescale 1ns/10ps
module msfd_monitor (
  input wire        core_clk,
  input wire        sys_rst,
  input wire        rx_end,
  input wire        rx_err,
  input wire        tx_ready,
  input wire        tx_valid,
  input wire [7:0]  tx_byte,
  input wire        reg_req,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire        dt_wr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Frame closed with an error while nothing is being sent
  sequence s_bad_frame;
    rx_end && rx_err && !tx_valid;
  endsequence
  // Reply byte offered and not yet taken
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  a_bad_silent: assert property (
    s_bad_frame |=> !tx_valid [*6]) else $error("reply after bad frame");
  a_tx_hold: assert property (
    s_stall |=> tx_valid && $stable(tx_byte)) else $error("reply byte lost");
  a_req_pulse: assert property (
    reg_req |=> !reg_req) else $error("request longer than one cycle");
  a_req_no_tx: assert property (
    reg_req |-> !tx_valid) else $error("reply during register access");
  a_addr_hold: assert property (
    $changed(reg_addr) || $changed(reg_wdata) |-> reg_req) else $error("address moved alone");
  a_dt_pulse: assert property (
    dt_wr |=> !dt_wr) else $error("date write longer than one cycle");
  a_dt_cause: assert property (
    dt_wr |-> $past(rx_end, 2) || $past(rx_end, 3) || $past(rx_end, 4)) else $error("date write without frame");
  a_rst_quiet: assert property (
    $fell(sys_rst) |-> !tx_valid && !reg_req && !dt_wr) else $error("outputs busy after reset");
endmodule // msfd_monitor

bind msfd_dispatch msfd_monitor mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .rx_end(rx_end), .rx_err(rx_err),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .reg_req(reg_req),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .dt_wr(dt_wr));

/* dv/msfd_reg_model.sv */
// Register store stand-in answering the dispatcher's register requests
`timescale 1ns/10ps
module msfd_reg_model (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        reg_req,
  input  wire [15:0] reg_addr,
  input  wire        nak,
  output reg         reg_ack,
  output wire [15:0] reg_rdata,
  output wire [7:0]  reg_exc
);
  reg [1:0] wait_cnt;
  reg       slow;
  // Alternate prompt and slow answers, never in the request cycle
  always @(posedge core_clk) begin
    reg_ack <= 1'b0;
    if (sys_rst) begin
      wait_cnt <= 2'h0;
      slow     <= 1'b0;
    end else if (reg_req) begin
      wait_cnt <= slow ? 2'h3 : 2'h1;
      slow     <= ~slow;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
      reg_ack  <= (wait_cnt == 2'h1);
    end
  end
  // Inverse shows outside the answer so a stale sample is caught
  assign reg_rdata = reg_ack ? reg_addr ^ 16'h5a5a : ~(reg_addr ^ 16'h5a5a);
  assign reg_exc   = reg_ack ? (nak ? 8'h07 : 8'h00) : 8'h5a;
endmodule // msfd_reg_model

/* dv/msfd_dispatch_bench.sv */
// Self-checking bench for the slave request dispatcher
`timescale 1ns/10ps
module msfd_dispatch_bench;
  localparam [7:0] own = 8'h2f;
  reg          core_clk, sys_rst, comm_param_chg, dev_busy, nak;
  reg          rx_valid, rx_end, rx_err, rx_overrun, tx_ready;
  reg  [7:0]   rx_byte;
  wire         tx_valid, reg_req, reg_we, reg_ack, dt_wr;
  wire [7:0]   tx_byte, reg_exc;
  wire [15:0]  reg_addr, reg_wdata, reg_rdata;
  wire [55:0]  dt_data;
  logic [7:0]  rq[$], eq[$], rdq[$];
  logic [31:0] seed = 32'h720ab876;
  logic [31:0] w;
  int          cnt[9];
  int          mismatches = 0;
  int          check_count = 0;

  msfd_dispatch dut (.core_clk(core_clk), .sys_rst(sys_rst), .slave_addr(own),
    .comm_param_chg(comm_param_chg), .dev_busy(dev_busy), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_end(rx_end), .rx_err(rx_err), .rx_overrun(rx_overrun), .tx_ready(tx_ready), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_exc(reg_exc), .tx_byte(tx_byte), .tx_valid(tx_valid), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .dt_wr(dt_wr), .dt_data(dt_data));
  msfd_reg_model regs (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_addr(reg_addr),
    .nak(nak), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_exc(reg_exc));

  // 250 MHz clock
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Check value, reflected, low byte sent first
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task final_report;
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [55:0] g, e);
    check_count++;
    if (g !== e) begin
      $display("Error %0t got %h exp %h", $time, g, e);
      mismatches++;
    end
  endtask

  // Counter model for a frame that arrived clean
  task upd(input logic [7:0] a, x);
    cnt[0]++;
    if (a == own || a == 0) cnt[3]++;
    if (a == 0) cnt[4]++;
    if (x != 0) cnt[2]++;
    if (x == 7) cnt[5]++;
    if (x == 6) cnt[6]++;
  endtask

  // Send rq, then take the reply against eq, or expect silence
  task xfer(input logic err, ovr);
    int i, n;
    logic [15:0] c;
    logic bad;
    c = crc(rq);
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    foreach (rq[j]) begin
      @(negedge core_clk);
      rx_valid = 1;
      rx_byte = rq[j];
    end
    @(negedge core_clk);
    rx_valid = 0;
    {rx_end, rx_err, rx_overrun} = {1'b1, err, ovr};
    @(negedge core_clk);
    {rx_end, rx_err, rx_overrun} = 3'h0;
    bad = 0;
    i = 0;
    n = 0;
    if (eq.size() == 0) repeat (12) begin
      @(negedge core_clk);
      bad = bad | tx_valid;
    end else begin
      c = crc(eq);
      eq.push_back(c[7:0]);
      eq.push_back(c[15:8]);
      while (i < eq.size()) begin
        @(negedge core_clk);
        tx_ready = |(rnd() & 3);
        if (tx_valid && tx_ready) begin
          chk(tx_byte, eq[i]);
          i++;
        end
        n++;
        if (n > 500) begin
          mismatches++;
          final_report;
        end
      end
    end
    chk(bad, 0);
    repeat (2) @(negedge core_clk);
    rq.delete();
    eq.delete();
  endtask

  task rd_cnt(input logic [7:0] s);
    int k;
    k = s - 8'h0b;
    // This frame's own counts land after its decode, so the reply shows the older value
    rq = {own, 8'h08, 8'h00, s, 8'h00, 8'h00};
    eq = {own, 8'h08, 8'h00, s, cnt[k][15:8], cnt[k][7:0]};
    upd(own, 0);
    xfer(0, 0);
    cnt[8]++;
  endtask

  task ev_rd;
    upd(own, 0);
    rq = {own, 8'h0b};
    eq = {own, 8'h0b, 8'h00, 8'h00, cnt[8][15:8], cnt[8][7:0]};
    xfer(0, 0);
  endtask

  // Main sequence
  initial begin
    {sys_rst, comm_param_chg, dev_busy, nak, rx_valid, rx_end, rx_err, rx_overrun, tx_ready} = 9'h100;
    rx_byte = 8'h00;
    foreach (cnt[i]) cnt[i] = 0;
    rdq = {own, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    upd(own, 0);
    rq = {own, 8'h64, 8'h06, 8'h04, 8'h09, 8'h02, 8'h97, 8'h02, 8'h99};
    eq = {own, 8'h64, 8'h06, 8'h04, 8'h09, 8'h58, 8'hcd, 8'h58, 8'hc3};
    xfer(0, 0);
    cnt[8]++;
    w = rnd();
    upd(own, 0);
    rq = {own, 8'h06, 8'h00, 8'h10, w[15:8], w[7:0]};
    eq = rq;
    xfer(0, 0);
    chk({reg_we, reg_addr, reg_wdata}, {1'b1, 16'h0010, w[15:0]});
    cnt[8]++;
    upd(own, 0);
    rq = {own, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'hab, 8'hcd, 8'h12, 8'h34};
    eq = rq[0:5];
    xfer(0, 0);
    chk({reg_we, reg_addr, reg_wdata}, {1'b1, 16'h0021, 16'h1234});
    cnt[8]++;
    upd(own, 0);
    rq = {own, 8'h2b, 8'h10, 8'h00, 8'h00, 8'h0e, 8'h0a, 8'h02, 8'h0e, 8'h20, 8'h0d, 8'hac};
    eq = rq;
    xfer(0, 0);
    chk(dt_data, 56'h0e0a020e200dac);
    cnt[8]++;
    // Two-register input read; values come from the register stand-in
    upd(own, 0);
    rq = {own, 8'h04, 8'h00, 8'h05, 8'h00, 8'h02};
    eq = {own, 8'h04, 8'h04, 8'h5a, 8'h5f, 8'h5a, 8'h5c};
    xfer(0, 0);
    cnt[8]++;
    // Scattered read with a wrong subfunction is refused as a bad value
    upd(own, 3);
    rq = {own, 8'h64, 8'h04, 8'h05, 8'h01, 8'h00, 8'h05};
    eq = {own, 8'he4, 8'h03};
    xfer(0, 0);
    // Busy and refused reads and an unknown function come back as exception frames
    dev_busy = 1;
    upd(own, 6);
    rq = rdq;
    eq = {own, 8'h83, 8'h06};
    xfer(0, 0);
    dev_busy = 0;
    nak = 1;
    upd(own, 7);
    rq = rdq;
    eq = {own, 8'h83, 8'h07};
    xfer(0, 0);
    nak = 0;
    upd(own, 1);
    rq = {own, 8'h41, 8'h00};
    eq = {own, 8'hc1, 8'h01};
    xfer(0, 0);
    // Silent cases still move the counters
    upd(8'h00, 1);
    rq = {8'h00, 8'h41, 8'h00};
    xfer(0, 0);
    upd(8'h30, 0);
    rq = {8'h30, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
    xfer(0, 0);
    cnt[1]++;
    rq = rdq;
    xfer(1, 0);
    cnt[1]++;
    cnt[7]++;
    rq = rdq;
    xfer(1, 1);
    for (logic [7:0] s = 8'h0b; s <= 8'h12; s++) rd_cnt(s);
    ev_rd();
    upd(own, 0);
    rq = {own, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00};
    eq = rq;
    xfer(0, 0);
    foreach (cnt[i]) cnt[i] = 0;
    cnt[8] = 1;
    rd_cnt(8'h0b);
    ev_rd();
    @(negedge core_clk);
    comm_param_chg = 1;
    @(negedge core_clk);
    comm_param_chg = 0;
    foreach (cnt[i]) cnt[i] = 0;
    ev_rd();
    rd_cnt(8'h0e);
    // Loss of supply in mid-run wipes every counter
    @(negedge core_clk);
    sys_rst = 1;
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    foreach (cnt[i]) cnt[i] = 0;
    rd_cnt(8'h0b);
    ev_rd();
    final_report;
  end
endmodule // msfd_dispatch_bench
